//--- rtlsc_cfg.svh
// Operation
// RULE1: Off, delay high: on after 2.3 s low.
// RULE2: Delay low first: turn on within 4 ms.
// RULE3: On, delay low first: off within 1 ms.
// RULE4: On, delay high: off after hold delay.
// RULE5: Output off 400 ms, then back on.
// RULE6: Simultaneous triggers: serve only the higher one.
// RULE7: Priority: button, then wake, then shutdown.
// RULE8: Controller repeats a discarded lower trigger; this code drops it and never repeats it.
// RULE9: Button or wake aborts long shutdown delay.
// RULE10: New shutdown needs low then rising again.
// RULE11: Power-on defaults: inputs idle, output on.
// RULE12: Hold delay scaled by trim setting multiplier.
// RULE13: Trim sensed briefly only after button falls.
// RULE14: Wake high with button high turns on.
// RULE15: Shutdown held 1 ms: 7.3 s or 0.6 ms.
// RULE16: Held button after turn-on needs release first.
// RULE17: Discharge pull-down active whenever switch is off.
// RULE18: Early button release clears counter, output unchanged.
// RULE19: One timebase; counters restart when trigger drops.
`ifndef RTLSC_CFG_SVH
`define RTLSC_CFG_SVH

`define RTLSC_CLK_HZ         250.0e6
`define RTLSC_T_TURN_ON_S    2.3
`define RTLSC_T_HOLD_S       7.5
`define RTLSC_T_PULSE_MS     400.0
`define RTLSC_T_SD_S         7.3
`define RTLSC_T_SD_ZERO_MS   0.6
`define RTLSC_T_QUAL_MS      1.0
`define RTLSC_T_TRIM_MS      2.0

`define RTLSC_CYC(t) ($rtoi($ceil((t) * `RTLSC_CLK_HZ - 0.001)))

`define RTLSC_TRIM_GND       3'h0
`define RTLSC_TRIM_3K9       3'h1
`define RTLSC_TRIM_10K       3'h2
`define RTLSC_TRIM_22K       3'h3
`define RTLSC_TRIM_47K       3'h4
`define RTLSC_TRIM_120K      3'h5
`define RTLSC_TRIM_SUPPLY    3'h6

`define RTLSC_PIN_RST_VAL    7'h4e

`endif

//--- rtlsc_pkg.sv
package rtlsc_pkg;

   typedef enum logic [2:0]
   {
      RTLSC_OFF   = 3'b000,
      RTLSC_ON    = 3'b001,
      RTLSC_QUAL  = 3'b010,
      RTLSC_SDLY  = 3'b011,
      RTLSC_PULSE = 3'b100
   } rtlsc_mode_type;

   typedef logic [2:0] rtlsc_trim_type;

   typedef struct packed
   {
      rtlsc_mode_type mode;
      logic           switch_en;
      logic           discharge_en;
      logic           trim_sense_en;
      logic           btn_prev;
      logic           wake_prev;
      logic           sd_prev;
      logic           dsel_prev;
      logic           btn_armed;
      logic           zero_sel;
      logic           sd_long;
      rtlsc_trim_type trim;
      logic [31:0]    btn_cnt;
      logic [31:0]    tmr;
      logic [31:0]    trim_cnt;
   } rtlsc_state_type;

endpackage

//--- rtlsc_sync.sv
`timescale 1ns/1ps

module rtlsc_sync
#(
   parameter int             WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stab;
   } rtlsc_sync_type;

   rtlsc_sync_type state_ff;
   rtlsc_sync_type nxt_state;

   always_comb
   begin
      nxt_state.meta = din;
      nxt_state.stab = state_ff.meta;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= {RST_VAL, RST_VAL};
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign dout = state_ff.stab;

endmodule

//--- rtlsc_ctrl.sv
`timescale 1ns/1ps
`include "rtlsc_cfg.svh"

module rtlsc_ctrl
#(
   parameter int unsigned TURN_ON_CYC = `RTLSC_CYC(`RTLSC_T_TURN_ON_S),
   parameter int unsigned HOLD_CYC    = `RTLSC_CYC(`RTLSC_T_HOLD_S),
   parameter int unsigned PULSE_CYC
      = `RTLSC_CYC(`RTLSC_T_PULSE_MS / 1000.0),
   parameter int unsigned SD_CYC      = `RTLSC_CYC(`RTLSC_T_SD_S),
   parameter int unsigned SD_ZERO_CYC
      = `RTLSC_CYC(`RTLSC_T_SD_ZERO_MS / 1000.0),
   parameter int unsigned QUAL_CYC
      = `RTLSC_CYC(`RTLSC_T_QUAL_MS / 1000.0),
   parameter int unsigned TRIM_CYC
      = `RTLSC_CYC(`RTLSC_T_TRIM_MS / 1000.0)
)
(
   input  wire logic            sys_clk,
   input  wire logic            nrst,
   input  wire logic            reset_button_n,
   input  wire logic            wake_input,
   input  wire logic            shutdown_req,
   input  wire logic            delay_sel,
   input  wire rtlsc_pkg::rtlsc_trim_type delay_trim_pin,
   output logic                 switch_en,
   output logic                 discharge_en,
   output logic                 trim_sense_en
);
   import rtlsc_pkg::*;

   logic            rst_n_int;
   logic [6:0]      pin_sync;
   logic            btn;
   logic            wake;
   logic            sd;
   logic            dsel;
   rtlsc_trim_type  trim_in;

   rtlsc_state_type state_ff;
   rtlsc_state_type nxt_state;

   // Power-on state: output on, pins taken as idle, trim at unity.
   localparam rtlsc_state_type RST_STATE = '{
      mode:          RTLSC_ON, // RULE11
      switch_en:     1'b1, // RULE11
      discharge_en:  1'b0,
      trim_sense_en: 1'b0,
      btn_prev:      1'b1, // RULE11
      wake_prev:     1'b0,
      sd_prev:       1'b0,
      dsel_prev:     1'b1, // RULE11
      btn_armed:     1'b1,
      zero_sel:      1'b0,
      sd_long:       1'b1,
      trim:          `RTLSC_TRIM_SUPPLY,
      btn_cnt:       32'h0,
      tmr:           32'h0,
      trim_cnt:      32'h0
   };

   logic            btn_fall;
   logic            wake_rise;
   logic            sd_rise;
   logic            ev_btn;
   logic            ev_wake;
   logic            ev_sd;
   logic            zero_now;
   logic            btn_hold;
   logic            on_done;
   logic            rst_done;
   logic            enter_on;
   logic [3:0]      mult;
   logic [31:0]     hold_tgt;
   logic [31:0]     sd_tgt;

   // Reset is released through two flip-flops of its own.
   rtlsc_sync
   #(
      .WIDTH   (1),
      .RST_VAL (1'b0)
   )
   u_rst_sync
   (
      .sys_clk (sys_clk),
      .rst_n   (nrst),
      .din     (1'b1),
      .dout    (rst_n_int)
   );

   // Pins come up in their idle levels so no edge is seen at reset.
   rtlsc_sync
   #(
      .WIDTH   (7),
      .RST_VAL (`RTLSC_PIN_RST_VAL)
   )
   u_pin_sync
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n_int),
      .din     ({reset_button_n,
                 wake_input,
                 shutdown_req,
                 delay_sel,
                 delay_trim_pin}),
      .dout    (pin_sync)
   );

   assign btn     = pin_sync[6];
   assign wake    = pin_sync[5];
   assign sd      = pin_sync[4];
   assign dsel    = pin_sync[3];
   assign trim_in = pin_sync[2:0];

   // Multiplier in quarters of the nominal hold delay.
   always_comb
   begin
      unique case (state_ff.trim)
         `RTLSC_TRIM_GND:  mult = 4'h2; // RULE12
         `RTLSC_TRIM_3K9:  mult = 4'h3; // RULE12
         `RTLSC_TRIM_10K:  mult = 4'h5; // RULE12
         `RTLSC_TRIM_22K:  mult = 4'h6; // RULE12
         `RTLSC_TRIM_47K:  mult = 4'h7; // RULE12
         `RTLSC_TRIM_120K: mult = 4'h8; // RULE12
         default:          mult = 4'h4; // RULE12
      endcase
   end

   // The product is formed wide so a long hold delay cannot wrap.
   assign hold_tgt = 32'((64'(HOLD_CYC) * 64'(mult)) >> 2);

   always_comb
   begin
      if (state_ff.sd_long)
      begin
         sd_tgt = 32'(SD_CYC); // RULE15
      end
      else
      begin
         sd_tgt = 32'(SD_ZERO_CYC); // RULE15
      end
   end

   assign btn_fall  = state_ff.btn_prev & ~btn;
   assign wake_rise = ~state_ff.wake_prev & wake;
   assign sd_rise   = ~state_ff.sd_prev & sd; // RULE10

   // Fixed priority: button, then wake, then shutdown; losers are dropped.
   always_comb
   begin
      ev_btn  = 1'b0;
      ev_wake = 1'b0;
      ev_sd   = 1'b0;
      if (btn_fall)
      begin
         ev_btn = 1'b1; // RULE7
      end
      else if (wake_rise)
      begin
         ev_wake = 1'b1; // RULE6
      end
      else if (sd_rise)
      begin
         ev_sd = 1'b1; // RULE6
      end
   end

   // Delay select is taken as it stood before the button fell.
   assign zero_now = btn_fall ? ~state_ff.dsel_prev : state_ff.zero_sel;
   assign btn_hold = ~btn & state_ff.btn_armed; // RULE16

   assign on_done = btn_hold & (zero_now // RULE2
      | (state_ff.btn_cnt >= 32'(TURN_ON_CYC - 1))); // RULE1
   assign rst_done = btn_hold & (zero_now // RULE3
      | (state_ff.btn_cnt >= hold_tgt - 32'h1)); // RULE4

   always_comb
   begin
      nxt_state = state_ff;
      enter_on  = 1'b0;

      nxt_state.btn_prev  = btn;
      nxt_state.wake_prev = wake;
      nxt_state.sd_prev   = sd;
      nxt_state.dsel_prev = dsel;

      // Hold counter runs only while the button stays low.
      if (btn)
      begin
         nxt_state.btn_cnt   = 32'h0; // RULE18
         nxt_state.btn_armed = 1'b1; // RULE16
      end
      else if (state_ff.btn_armed && state_ff.btn_cnt != 32'hffffffff)
      begin
         nxt_state.btn_cnt = state_ff.btn_cnt + 32'h1; // RULE19
      end

      if (btn_fall)
      begin
         nxt_state.zero_sel      = ~state_ff.dsel_prev;
         nxt_state.trim_sense_en = 1'b1; // RULE13
         nxt_state.trim_cnt      = 32'h0;
      end
      else if (state_ff.trim_sense_en)
      begin
         nxt_state.trim_cnt = state_ff.trim_cnt + 32'h1;
         if (state_ff.trim_cnt >= 32'(TRIM_CYC - 1))
         begin
            nxt_state.trim          = trim_in; // RULE13
            nxt_state.trim_sense_en = 1'b0; // RULE13
         end
      end

      unique case (state_ff.mode)
         RTLSC_OFF:
         begin
            if (on_done || (wake && btn)) // RULE14
            begin
               nxt_state.mode = RTLSC_ON;
               enter_on       = 1'b1;
            end
         end
         RTLSC_ON:
         begin
            if (rst_done)
            begin
               nxt_state.mode    = RTLSC_PULSE;
               nxt_state.tmr     = 32'h0;
               nxt_state.btn_cnt = 32'h0;
            end
            else if (ev_sd)
            begin
               nxt_state.mode = RTLSC_QUAL; // RULE15
               nxt_state.tmr  = 32'h0;
            end
         end
         // A request that drops during qualify is forgotten.
         RTLSC_QUAL:
         begin
            nxt_state.tmr = state_ff.tmr + 32'h1;
            if (ev_btn || ev_wake || !sd)
            begin
               nxt_state.mode = RTLSC_ON; // RULE19
            end
            else if (state_ff.tmr >= 32'(QUAL_CYC - 1))
            begin
               nxt_state.mode    = RTLSC_SDLY; // RULE15
               nxt_state.tmr     = 32'h0;
               nxt_state.sd_long = dsel;
            end
         end
         // Only the long delay can be aborted by a higher input.
         RTLSC_SDLY:
         begin
            nxt_state.tmr = state_ff.tmr + 32'h1;
            if (state_ff.sd_long && (ev_btn || ev_wake))
            begin
               nxt_state.mode = RTLSC_ON; // RULE9
            end
            else if (state_ff.tmr >= sd_tgt - 32'h1)
            begin
               nxt_state.mode    = RTLSC_OFF; // RULE15
               nxt_state.btn_cnt = 32'h0;
            end
         end
         RTLSC_PULSE:
         begin
            nxt_state.tmr = state_ff.tmr + 32'h1;
            if (state_ff.tmr >= 32'(PULSE_CYC - 1))
            begin
               nxt_state.mode = RTLSC_ON; // RULE5
               enter_on       = 1'b1;
            end
         end
         default:
         begin
            nxt_state.mode = RTLSC_ON;
         end
      endcase

      // A button still held across turn-on must be released first.
      if (enter_on)
      begin
         nxt_state.btn_armed = 1'b0; // RULE16
         nxt_state.btn_cnt   = 32'h0;
      end

      nxt_state.switch_en = (nxt_state.mode != RTLSC_OFF)
         && (nxt_state.mode != RTLSC_PULSE); // RULE5
      nxt_state.discharge_en = ~nxt_state.switch_en; // RULE17
   end

   always_ff @(posedge sys_clk or negedge rst_n_int)
   begin
      if (!rst_n_int)
      begin
         state_ff <= RST_STATE; // RULE11
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign switch_en     = state_ff.switch_en;
   assign discharge_en  = state_ff.discharge_en;
   assign trim_sense_en = state_ff.trim_sense_en;

endmodule

//--- rtlsc_monitor.sv
`timescale 1ns/1ps
module rtlsc_monitor
(
   input wire logic                      sys_clk,
   input wire logic                      nrst,
   input wire logic                      reset_button_n,
   input wire logic                      wake_input,
   input wire logic                      shutdown_req,
   input wire logic                      delay_sel,
   input wire rtlsc_pkg::rtlsc_trim_type delay_trim_pin,
   input wire logic                      switch_en,
   input wire logic                      discharge_en,
   input wire logic                      trim_sense_en
);
   import rtlsc_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   property p_dis;
      discharge_en == !switch_en;
   endproperty
   a_dis: assert property (p_dis) else $error("discharge wrong");
   property p_zon;
      !switch_en && $fell(reset_button_n) && !delay_sel
         && !$past(delay_sel, 3) |-> ##[1:4] switch_en;
   endproperty
   a_zon: assert property (p_zon) else $error("no quick on");
   property p_zoff;
      switch_en && $fell(reset_button_n) && !delay_sel && !shutdown_req
         && !$past(delay_sel, 3) |-> ##[1:4] !switch_en;
   endproperty
   a_zoff: assert property (p_zoff) else $error("no quick off");
   property p_pulse;
      $fell(switch_en) |=> !switch_en [*8];
   endproperty
   a_pulse: assert property (p_pulse) else $error("off too short");
   property p_trim;
      $rose(trim_sense_en) |-> trim_sense_en [*5] ##1 !trim_sense_en;
   endproperty
   a_trim: assert property (p_trim) else $error("trim window");
   property p_tcause;
      $rose(trim_sense_en) |->
         !$past(reset_button_n, 3) && $past(reset_button_n, 4);
   endproperty
   a_tcause: assert property (p_tcause) else $error("trim cause");
   property p_wake;
      $rose(wake_input) && reset_button_n && !switch_en
         |-> ##[1:4] switch_en;
   endproperty
   a_wake: assert property (p_wake) else $error("wake no on");
   property p_rel;
      switch_en && $rose(reset_button_n) |=> switch_en [*4];
   endproperty
   a_rel: assert property (p_rel) else $error("release cut");
   property p_shut;
      $fell(switch_en) && $past(reset_button_n, 3)
         |-> $past(shutdown_req, 8);
   endproperty
   a_shut: assert property (p_shut) else $error("bad off");
   c_zoff: cover property ($fell(switch_en) && !delay_sel);
   c_won: cover property ($rose(switch_en) && wake_input);
   c_trim: cover property ($rose(trim_sense_en));
endmodule

//--- rtlsc_far.sv
`timescale 1ns/1ps
module rtlsc_far
(
   input  wire logic                sys_clk,
   input  wire logic                trim_sense_en,
   output logic                     reset_button_n,
   output logic                     wake_input,
   output logic                     shutdown_req,
   output logic                     delay_sel,
   output rtlsc_pkg::rtlsc_trim_type delay_trim_pin
);
   import rtlsc_pkg::*;
   rtlsc_trim_type trim_code = 3'h6;
   initial
   begin
      reset_button_n = 1'h1;
      wake_input = 1'h0;
      shutdown_req = 1'h0;
      delay_sel = 1'h1;
   end
   // A disconnected trim pin shows garbage, not the resistor code.
   assign delay_trim_pin = trim_sense_en ? trim_code : ~trim_code;
   task automatic set(input logic b, w, s, d);
      @(posedge sys_clk);
      #1;
      reset_button_n = b;
      wake_input = w;
      shutdown_req = s;
      delay_sel = d;
   endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
   import rtlsc_pkg::*;
   logic           sys_clk = 1'h0;
   logic           nrst = 1'h0;
   logic           reset_button_n, wake_input, shutdown_req, delay_sel;
   rtlsc_trim_type delay_trim_pin;
   logic           switch_en, discharge_en, trim_sense_en;
   int             miscompares = 0;
   int             samples_checked = 0;
   int             cycles = 0;
   int             n;
   int             m[7] = '{2, 3, 5, 6, 7, 8, 4};
   localparam int T_ON    = 40;
   localparam int T_HOLD  = 80;
   localparam int T_PULSE = 20;
   localparam int T_SD    = 60;
   localparam int T_SDZ   = 6;
   localparam int T_QUAL  = 10;
   localparam int T_TRIM  = 5;
   rtlsc_ctrl #(.TURN_ON_CYC(T_ON), .HOLD_CYC(T_HOLD),
      .PULSE_CYC(T_PULSE), .SD_CYC(T_SD), .SD_ZERO_CYC(T_SDZ),
      .QUAL_CYC(T_QUAL), .TRIM_CYC(T_TRIM))
   rtlsc_ctrl_inst (.sys_clk, .nrst, .reset_button_n, .wake_input,
      .shutdown_req, .delay_sel, .delay_trim_pin, .switch_en,
      .discharge_en, .trim_sense_en);
   rtlsc_far rtlsc_far_inst (.sys_clk, .trim_sense_en, .reset_button_n,
      .wake_input, .shutdown_req, .delay_sel, .delay_trim_pin);
   initial
      forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         miscompares++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #2;
   endtask
   task automatic wait_sw(input logic v, input int lim);
      n = 0;
      while (switch_en !== v && n < lim)
      begin
         @(posedge sys_clk);
         #2;
         n++;
      end
   endtask
   task automatic chk(input logic [31:0] got, exp, input int tol);
      samples_checked++;
      if ((got > exp + tol || got + tol < exp) !== 1'b0)
      begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic sw(input logic b, w, s, d, input logic v, input int e);
      rtlsc_far_inst.set(b, w, s, d);
      wait_sw(v, 300);
      chk(n, e, 2);
      chk(32'(discharge_en), 32'(!v), 0);
   endtask
   task automatic t_hold();
      for (int i = 0; i < 7; i++)
      begin
         @(posedge sys_clk);
         #1;
         rtlsc_far_inst.trim_code = 3'(i);
         sw(0, 0, 0, 1, 0, 3 + m[i] * T_HOLD / 4);
         wait_sw(1, 60);
         chk(n, T_PULSE, 2);
         cyc(170);
         chk(32'(switch_en), 1, 0);
         rtlsc_far_inst.set(1, 0, 0, 1);
         cyc(5);
      end
   endtask
   task automatic t_early();
      rtlsc_far_inst.set(0, 0, 0, 1);
      cyc(50);
      rtlsc_far_inst.set(1, 0, 0, 1);
      cyc(5);
      rtlsc_far_inst.set(0, 0, 0, 1);
      cyc(60);
      chk(32'(switch_en), 1, 0);
      rtlsc_far_inst.set(1, 0, 0, 1);
   endtask
   task automatic t_zero();
      rtlsc_far_inst.set(1, 0, 0, 0);
      cyc(5);
      sw(0, 0, 0, 0, 0, 4);
      wait_sw(1, 60);
      chk(n, 20, 2);
      rtlsc_far_inst.set(1, 0, 0, 0);
      cyc(5);
      sw(1, 0, 1, 0, 0, 19);
      rtlsc_far_inst.set(1, 0, 0, 0);
      cyc(5);
      sw(0, 0, 0, 0, 1, 4);
      rtlsc_far_inst.set(1, 0, 0, 1);
      cyc(5);
   endtask
   task automatic t_long();
      sw(1, 0, 1, 1, 0, 73);
      sw(0, 0, 0, 1, 1, 43);
      rtlsc_far_inst.set(1, 0, 0, 1);
      cyc(5);
      sw(1, 0, 1, 0, 0, 19);
      rtlsc_far_inst.set(1, 0, 0, 1);
      cyc(5);
      sw(1, 1, 0, 1, 1, 4);
      rtlsc_far_inst.set(1, 0, 0, 1);
   endtask
   task automatic t_abort();
      rtlsc_far_inst.set(1, 0, 1, 1);
      cyc(30);
      rtlsc_far_inst.set(1, 1, 1, 1);
      cyc(3);
      rtlsc_far_inst.set(1, 0, 1, 1);
      cyc(100);
      chk(32'(switch_en), 1, 0);
      rtlsc_far_inst.set(1, 0, 0, 1);
      cyc(3);
      sw(1, 0, 1, 1, 0, 73);
      cyc(5);
      sw(1, 1, 0, 1, 1, 4);
   endtask
   task automatic t_prio();
      rtlsc_far_inst.set(0, 0, 1, 1);
      cyc(20);
      rtlsc_far_inst.set(1, 0, 1, 1);
      cyc(120);
      chk(32'(switch_en), 1, 0);
      rtlsc_far_inst.set(1, 0, 0, 1);
      cyc(3);
      sw(1, 0, 1, 1, 0, 73);
   endtask
   task automatic t_por();
      rtlsc_far_inst.set(1, 0, 0, 1);
      cyc(10);
      chk(32'(switch_en), 0, 0);
      @(posedge sys_clk);
      #1;
      nrst = 1'h0;
      cyc(3);
      chk(32'(switch_en), 1, 0);
      chk(32'(discharge_en), 0, 0);
      @(posedge sys_clk);
      #1;
      nrst = 1'h1;
      cyc(6);
      chk(32'(switch_en), 1, 0);
      chk(32'(trim_sense_en), 0, 0);
   endtask
   initial
   begin
      repeat (20) @(posedge sys_clk);
      #1;
      nrst = 1'h1;
      cyc(6);
      chk(32'(switch_en), 1, 0);
      chk(32'(trim_sense_en), 0, 0);
      t_hold();
      t_early();
      t_zero();
      t_long();
      t_abort();
      t_prio();
      t_por();
      finish_test();
   end
endmodule
bind rtlsc_ctrl rtlsc_monitor rtlsc_monitor_inst (.sys_clk, .nrst,
   .reset_button_n, .wake_input, .shutdown_req, .delay_sel,
   .delay_trim_pin, .switch_en, .discharge_en, .trim_sense_en);
